//--- hw/stereo_adc_serial_output.sv
// Clock derivation and serial word formatter of a stereo converter.
`timescale 1ns/1ns

module stereo_adc_serial_output
    import adc_serial_pkg::*;
#(
    parameter int CAL_WORDS = CAL_WORDS_DEF
)
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    input wire logic CLOCK_RATIO_SELECT,
    input ser_mode_t SERIAL_MODE,
    input wire logic BCLK_INVERT,
    input wire logic DIGITAL_POWERDOWN,
    input wire logic SAMPLE_STROBE,
    input wire logic signed [LEVEL_W-1:0] LEFT_LEVEL,
    input wire logic signed [LEVEL_W-1:0] RIGHT_LEVEL,
    input wire logic WORD_SELECT_I,
    output logic WORD_SELECT_O,
    output logic WORD_SELECT_OE_N,
    input wire logic BIT_CLOCK_I,
    output logic BIT_CLOCK_O,
    output logic BIT_CLOCK_OE_N,
    input wire logic FRAME_ENABLE_I,
    output logic FRAME_ENABLE_O,
    output logic FRAME_ENABLE_OE_N,
    output logic MODULATOR_CLOCK_OUT,
    output logic SERIAL_OUT,
    output logic CAL_ACTIVE
);

    localparam int CAL_CW = $clog2(CAL_WORDS + 1);

    // ========================================================================
    // Pin synchronisers
    logic [NPINS-1:0] pin_raw;
    logic [NPINS-1:0] pin_f;
    logic [NPINS-1:0] pin_prev_r;

    assign pin_raw = {DIGITAL_POWERDOWN, FRAME_ENABLE_I, BIT_CLOCK_I,
                      WORD_SELECT_I};

    for (genvar i = 0; i < NPINS; i++)
    begin : g_sync
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic f_r;
        // A level only counts once two late stages agree, which drops
        // single-cycle glitches from the host at the cost of latency.
        always_ff @(posedge CLK or negedge RSTN)
        begin
            if (!RSTN)
            begin
                s1_r <= PIN_RESET[i];
                s2_r <= PIN_RESET[i];
                s3_r <= PIN_RESET[i];
                f_r <= PIN_RESET[i];
            end
            else if (CLK_EN)
            begin
                s1_r <= pin_raw[i];
                s2_r <= s1_r;
                s3_r <= s2_r;
                if (s2_r == s3_r)
                    f_r <= s3_r;
            end
        end
        assign pin_f[i] = f_r;
    end

    // ========================================================================
    // Power state and calibration
    pwr_state_t state_r;
    pwr_state_t state_nxt;
    logic [CAL_CW-1:0] cal_cnt_r;
    logic [CAL_CW-1:0] cal_cnt_nxt;
    logic active;
    logic release_evt;
    logic left_start;
    logic load_evt;

    assign active = ~pin_f[PIN_PD];
    assign release_evt = pin_prev_r[PIN_PD] & ~pin_f[PIN_PD];

    always_comb
    begin
        state_nxt = state_r;
        cal_cnt_nxt = cal_cnt_r;
        unique case (state_r)
            PWR_DOWN:
                if (release_evt)
                begin
                    state_nxt = CALIBRATE;
                    cal_cnt_nxt = '0;
                end
            CALIBRATE:
                if (left_start)
                begin
                    cal_cnt_nxt = cal_cnt_r + 1'b1;
                    if (cal_cnt_r == CAL_CW'(CAL_WORDS - 1))
                        state_nxt = RUN;
                end
            RUN: ;
            default: state_nxt = PWR_DOWN;
        endcase
        if (!active)
            state_nxt = PWR_DOWN;
    end

    // ========================================================================
    // Modulator clock divider
    logic [1:0] div_cnt_r;
    logic [1:0] div_max;
    logic [2:0] div_sum;
    logic [1:0] div_nxt;
    logic [1:0] edge_cnt_r;
    logic aligned_r;
    logic modclk_r;
    logic ws_rise;
    logic late_align;

    assign div_max = (CLOCK_RATIO_SELECT ? DIV_HIGH : DIV_LOW) - 2'h1;
    // The first word select rise, if at or after edge two, slips the divide-by-three
    // phase by one master cycle; divide-by-two never slips.
    assign late_align = ws_rise & ~aligned_r & CLOCK_RATIO_SELECT
                        & (edge_cnt_r >= ALIGN_EDGE);
    assign div_sum = {1'b0, div_cnt_r} + (late_align ? 3'h2 : 3'h1);
    assign div_nxt = (div_sum > {1'b0, div_max})
                     ? 2'(div_sum - {1'b0, div_max} - 3'h1)
                     : div_sum[1:0];
    assign MODULATOR_CLOCK_OUT = modclk_r;

    // ========================================================================
    // Master timing counters
    logic [2:0] half;
    logic [2:0] ph_r;
    logic [BIT_W-1:0] bit_r;
    logic [4:0] slot;
    logic master;
    logic ws_m;
    logic bclk_m;
    logic fe_m;
    logic bit_start;

    assign master = (SERIAL_MODE == SER_MASTER);
    assign half = CLOCK_RATIO_SELECT ? BCLK_HALF_HIGH : BCLK_HALF_LOW;
    assign slot = bit_r[4:0];
    assign bit_start = (ph_r == 3'h0);
    assign ws_m = ~bit_r[BIT_W-1];
    assign bclk_m = (ph_r < half);
    assign fe_m = (slot >= FE_FIRST) && (slot <= FE_LAST);

    assign WORD_SELECT_O = ws_m;
    assign FRAME_ENABLE_O = fe_m;
    assign BIT_CLOCK_O = bclk_m ^ BCLK_INVERT;
    assign WORD_SELECT_OE_N = ~master;
    assign FRAME_ENABLE_OE_N = ~master;
    assign BIT_CLOCK_OE_N = ~master;

    // ========================================================================
    // Serial events
    logic ws_level;
    logic ws_prev_r;
    logic bclk_eff;
    logic bclk_prev_r;
    logic shift_evt;
    logic left_now;

    assign ws_level = master ? ws_m : pin_f[PIN_WS];
    assign bclk_eff = pin_f[PIN_BCLK] ^ BCLK_INVERT;
    assign load_evt = active & (master ? (bit_start && slot == 5'h0)
                                       : (ws_level != ws_prev_r));
    assign left_now = ws_level;
    assign left_start = load_evt & left_now;
    assign ws_rise = left_start;
    assign shift_evt = active & ~load_evt & (master
        ? (bit_start && slot >= FIRST_SHIFT)
        : (bclk_eff & ~bclk_prev_r
           & ((SERIAL_MODE == SER_SLAVE_FIXED)
              | (SERIAL_MODE == SER_SLAVE_HOST && pin_f[PIN_FE]))));

    // ========================================================================
    // Sample pair and word assembly
    chan_word_t enc [2];
    chan_word_t pair_r [2];
    chan_word_t hold_r;
    chan_word_t cur;
    logic [SLOT_BITS-1:0] sh_r;
    logic [SLOT_BITS-1:0] load_word;
    logic fill_r;

    tag_encoder u_enc_left (
        .level(LEFT_LEVEL),
        .word(enc[0])
    );
    tag_encoder u_enc_right (
        .level(RIGHT_LEVEL),
        .word(enc[1])
    );

    // The right word comes from the pair captured at the left edge, so a
    // strobe between the two edges cannot split the pair.
    assign cur = (state_r != RUN) ? '0 : (left_now ? pair_r[0] : hold_r);
    assign load_word = {cur.sample, cur.tag, ~left_now,
                        {FILL_W{left_now}}};
    assign SERIAL_OUT = sh_r[SLOT_BITS-1];
    assign CAL_ACTIVE = (state_r == CALIBRATE);

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_r <= PWR_DOWN;
            cal_cnt_r <= '0;
            pin_prev_r <= PIN_RESET;
            ws_prev_r <= 1'b0;
            bclk_prev_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            state_r <= state_nxt;
            cal_cnt_r <= cal_cnt_nxt;
            pin_prev_r <= pin_f;
            ws_prev_r <= ws_level;
            bclk_prev_r <= bclk_eff;
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            div_cnt_r <= '0;
            modclk_r <= 1'b0;
            edge_cnt_r <= '0;
            aligned_r <= 1'b0;
            ph_r <= '0;
            bit_r <= '0;
        end
        else if (CLK_EN)
        begin
            if (!active)
            begin
                div_cnt_r <= '0;
                modclk_r <= 1'b0;
                edge_cnt_r <= '0;
                aligned_r <= 1'b0;
                ph_r <= '0;
                bit_r <= '0;
            end
            else
            begin
                div_cnt_r <= div_nxt;
                modclk_r <= (div_nxt == 2'h0);
                if (edge_cnt_r < ALIGN_EDGE)
                    edge_cnt_r <= edge_cnt_r + 2'h1;
                if (ws_rise)
                    aligned_r <= 1'b1;
                ph_r <= (ph_r == 3'((half << 1) - 3'h1)) ? 3'h0
                                                         : ph_r + 3'h1;
                if (ph_r == 3'((half << 1) - 3'h1))
                    bit_r <= bit_r + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pair_r[0] <= '0;
            pair_r[1] <= '0;
            hold_r <= '0;
            sh_r <= '0;
            fill_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (SAMPLE_STROBE)
            begin
                pair_r[0] <= enc[0];
                pair_r[1] <= enc[1];
            end
            if (!active)
                sh_r <= '0;
            else if (load_evt)
            begin
                sh_r <= load_word;
                fill_r <= left_now;
                if (left_now)
                    hold_r <= pair_r[1];
            end
            else if (shift_evt)
                sh_r <= {sh_r[SLOT_BITS-2:0], fill_r};
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN || !CLK_EN);

    logic [7:0] fe_run_r;
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            fe_run_r <= '0;
        else if (CLK_EN)
            fe_run_r <= FRAME_ENABLE_O ? fe_run_r + 8'h1 : 8'h0;
    end

    property p_div2;
        (!CLOCK_RATIO_SELECT && !$past(CLOCK_RATIO_SELECT)
         && !$past(CLOCK_RATIO_SELECT, 2) && active && $past(active)
         && $past(active, 2) && $past(CLK_EN))
        |-> MODULATOR_CLOCK_OUT != $past(MODULATOR_CLOCK_OUT);
    endproperty
    a_div2: assert property (p_div2) else $error("div2 clock stalled");

    property p_div3;
        ($rose(MODULATOR_CLOCK_OUT) && CLOCK_RATIO_SELECT && aligned_r)
        |-> ##1 !MODULATOR_CLOCK_OUT [*2] ##1 (MODULATOR_CLOCK_OUT || !active);
    endproperty
    a_div3: assert property (p_div3) else $error("div3 period wrong");

    property p_align;
        (late_align && active && aligned_r == 1'b0) |=> aligned_r;
    endproperty
    a_align: assert property (p_align) else $error("alignment lost");

    property p_pd_hold;
        (!active) |=> (ph_r == 3'h0 && bit_r == '0 && SERIAL_OUT == 1'b0);
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("not held");

    property p_fe_rise;
        (master && $rose(FRAME_ENABLE_O))
        |-> (slot == FE_FIRST && $past(slot) == 5'h0);
    endproperty
    a_fe_rise: assert property (p_fe_rise) else $error("frame late");

    property p_fe_len;
        (master && active && $past(active) && $fell(FRAME_ENABLE_O)
         && $stable(CLOCK_RATIO_SELECT))
        |-> fe_run_r == 8'(SAMPLE_W * 2 * half);
    endproperty
    a_fe_len: assert property (p_fe_len) else $error("frame width");

    property p_ws64;
        (master && active && slot == 5'(SLOT_BITS - 1) && bit_r != '0
         && ph_r == 3'((half << 1) - 3'h1))
        |=> WORD_SELECT_O != $past(WORD_SELECT_O);
    endproperty
    a_ws64: assert property (p_ws64) else $error("word select slot");

    property p_load;
        load_evt |=> SERIAL_OUT == $past(load_word[SLOT_BITS-1]);
    endproperty
    a_load: assert property (p_load) else $error("MSB not loaded");

    property p_host;
        (SERIAL_MODE == SER_SLAVE_HOST && active && !pin_f[PIN_FE]
         && !load_evt)
        |=> $stable(sh_r);
    endproperty
    a_host: assert property (p_host) else $error("shift while held");

    property p_cal_zero;
        (state_r == CALIBRATE && load_evt) |=> SERIAL_OUT == 1'b0;
    endproperty
    a_cal_zero: assert property (p_cal_zero) else $error("cal nonzero");

    c_master_left: cover property (master && left_start);
    c_host_shift: cover property (SERIAL_MODE == SER_SLAVE_HOST && shift_evt);
    c_cal_done: cover property (state_r == CALIBRATE ##1 state_r == RUN);
    c_late: cover property (late_align);

endmodule

//--- hw/tag_encoder.sv
// Saturates one channel level to a sample and grades it into tag bits.
`timescale 1ns/1ns
module tag_encoder
    import adc_serial_pkg::*;
(
    input wire logic signed [LEVEL_W-1:0] level,
    output chan_word_t word
);

    logic [LEVEL_W-1:0] mag;
    logic [TAG_W-1:0] tag_sel;
    logic [SAMPLE_W-1:0] sample_sel;

    // The magnitude is unsigned one bit wider in range, so the most
    // negative level still grades as the largest overdrive.
    assign mag = level[LEVEL_W-1] ? (~level + 18'h00001) : level;

    assign tag_sel = (mag >= LVL_1375) ? TAG_OVR3 :
                     (mag >= LVL_1250) ? TAG_OVR2 :
                     (mag >= LVL_1125) ? TAG_OVR1 :
                     (mag >= LVL_FS) ? TAG_OVR0 :
                     (mag >= LVL_M1DB) ? TAG_NEAR1 :
                     (mag >= LVL_M3DB) ? TAG_NEAR3 :
                     (mag >= LVL_M6DB) ? TAG_NEAR6 : TAG_LOW;

    assign sample_sel = (level > LEVEL_POS_LIM) ? SAMPLE_MAX :
                        (level < LEVEL_NEG_LIM) ? SAMPLE_MIN :
                        level[SAMPLE_W-1:0];

    assign word.sample = sample_sel;
    assign word.tag = tag_sel;

endmodule

//--- include/adc_serial_pkg.sv
// Shared constants, types and encodings for the stereo serial output block.
package adc_serial_pkg;

    // ========================================================================
    // Word layout
    localparam int SAMPLE_W = 16;
    localparam int TAG_W = 3;
    localparam int LEVEL_W = 18;
    localparam int SLOT_BITS = 32;
    localparam int FRAME_BITS = 2 * SLOT_BITS;
    localparam int FILL_W = SLOT_BITS - SAMPLE_W - TAG_W - 1;
    localparam int BIT_W = $clog2(FRAME_BITS);

    // ========================================================================
    // Clock ratios
    localparam int RATIO_LOW = 256;
    localparam int RATIO_HIGH = 384;
    localparam int MODCLK_RATIO = 128;
    localparam logic [2:0] BCLK_HALF_LOW = 3'(RATIO_LOW / (2 * FRAME_BITS));
    localparam logic [2:0] BCLK_HALF_HIGH = 3'(RATIO_HIGH / (2 * FRAME_BITS));
    localparam logic [1:0] DIV_LOW = 2'(RATIO_LOW / MODCLK_RATIO);
    localparam logic [1:0] DIV_HIGH = 2'(RATIO_HIGH / MODCLK_RATIO);
    localparam logic [1:0] ALIGN_EDGE = 2'h2;
    localparam logic [4:0] FE_FIRST = 5'h1;
    localparam logic [4:0] FE_LAST = 5'(SAMPLE_W);
    localparam logic [4:0] FIRST_SHIFT = 5'h2;
    localparam int CAL_WORDS_DEF = 4096;

    // ========================================================================
    // Pin synchroniser slots
    localparam int NPINS = 4;
    localparam int PIN_WS = 0;
    localparam int PIN_BCLK = 1;
    localparam int PIN_FE = 2;
    localparam int PIN_PD = 3;
    localparam logic [NPINS-1:0] PIN_RESET = 4'h8;

    // ========================================================================
    // Level thresholds, full scale is 2^15 level units
    localparam logic [LEVEL_W-1:0] LVL_1375 = 18'h0b000;
    localparam logic [LEVEL_W-1:0] LVL_1250 = 18'h0a000;
    localparam logic [LEVEL_W-1:0] LVL_1125 = 18'h09000;
    localparam logic [LEVEL_W-1:0] LVL_FS = 18'h08000;
    localparam logic [LEVEL_W-1:0] LVL_M1DB = 18'h071fe;
    localparam logic [LEVEL_W-1:0] LVL_M3DB = 18'h059fe;
    localparam logic [LEVEL_W-1:0] LVL_M6DB = 18'h04027;
    localparam logic signed [LEVEL_W-1:0] LEVEL_POS_LIM = 18'sh07fff;
    localparam logic signed [LEVEL_W-1:0] LEVEL_NEG_LIM = 18'sh38000;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 16'h7fff;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 16'h8000;

    localparam logic [TAG_W-1:0] TAG_OVR3 = 3'h7;
    localparam logic [TAG_W-1:0] TAG_OVR2 = 3'h6;
    localparam logic [TAG_W-1:0] TAG_OVR1 = 3'h5;
    localparam logic [TAG_W-1:0] TAG_OVR0 = 3'h4;
    localparam logic [TAG_W-1:0] TAG_NEAR1 = 3'h3;
    localparam logic [TAG_W-1:0] TAG_NEAR3 = 3'h2;
    localparam logic [TAG_W-1:0] TAG_NEAR6 = 3'h1;
    localparam logic [TAG_W-1:0] TAG_LOW = 3'h0;

    // ========================================================================
    // Types
    typedef enum logic [1:0] {SER_MASTER, SER_SLAVE_FIXED, SER_SLAVE_HOST}
        ser_mode_t;
    typedef enum logic [1:0] {PWR_DOWN, CALIBRATE, RUN} pwr_state_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] sample;
        logic [TAG_W-1:0] tag;
    } chan_word_t;

endpackage

//--- testbench/host_clock_model.sv
// Host model that drives word select, bit clock and frame enable.
`timescale 1ns/1ns
module host_clock_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic host_frame,
    output logic ws,
    output logic bclk,
    output logic fe
);
    // ====================================================================
    // Frame counter
    // A word period is 192 master clocks with 24 bit clocks of 4 clocks
    // per half; slower than ideal so each level outlives the pin filter.
    logic [8:0] cnt_r;
    logic [8:0] half;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_r <= 9'h0;
        else if (run)
            cnt_r <= (cnt_r == 9'h17f) ? 9'h0 : cnt_r + 9'h1;
    end

    // ====================================================================
    // Pin levels
    assign half = (cnt_r >= 9'hc0) ? cnt_r - 9'hc0 : cnt_r;
    assign ws = (cnt_r < 9'hc0);
    assign bclk = half[2];
    assign fe = !host_frame || (half >= 9'h1e && half < 9'ha8);
endmodule

//--- testbench/stereo_adc_serial_output_test.sv
// Self-checking bench for the stereo serial output block.
`timescale 1ns/1ns
module stereo_adc_serial_output_test
    import adc_serial_pkg::*;
;
    // ====================================================================
    // Signals
    logic CLK = 1'b0;
    logic RSTN, CLK_EN, CLOCK_RATIO_SELECT, BCLK_INVERT, DIGITAL_POWERDOWN;
    logic SAMPLE_STROBE, WORD_SELECT_O, WORD_SELECT_OE_N, BIT_CLOCK_O;
    logic BIT_CLOCK_OE_N, FRAME_ENABLE_O, FRAME_ENABLE_OE_N;
    logic MODULATOR_CLOCK_OUT, SERIAL_OUT, CAL_ACTIVE;
    ser_mode_t SERIAL_MODE;
    logic signed [LEVEL_W-1:0] LEFT_LEVEL, RIGHT_LEVEL;
    logic ws_w, bc_w, fe_w, h_ws, h_bc, h_fe, hrun, ws_q, bc_q, bc, armed;
    logic [31:0] got, seed;
    logic [31:0] q[$];
    int rises, feh, mods, cnt, per, smp, fail_count, checked;
    logic signed [LEVEL_W-1:0] tbl[11] = '{18'h0c350, 18'h0a7f8, 18'h09470,
        18'h084d0, 18'h07fff, 18'h38ad0, 18'h061a8, 18'h04e20, 18'h003e8,
        18'h33cb0, 18'h37fff};

    always #25 CLK = ~CLK;
    assign ws_w = WORD_SELECT_OE_N ? h_ws : WORD_SELECT_O;
    assign bc_w = BIT_CLOCK_OE_N ? h_bc : BIT_CLOCK_O;
    assign fe_w = FRAME_ENABLE_OE_N ? h_fe : FRAME_ENABLE_O;
    assign bc = BIT_CLOCK_O ^ BCLK_INVERT;
    assign per = (SERIAL_MODE != SER_MASTER) ? 8 : CLOCK_RATIO_SELECT ? 6 : 4;
    assign smp = (per == 8) ? 7 : (per == 6) ? 4 : 3;

    stereo_adc_serial_output #(.CAL_WORDS(4)) u_stereo_adc_serial_output
    (
        .CLK(CLK),
        .RSTN(RSTN),
        .CLK_EN(CLK_EN),
        .CLOCK_RATIO_SELECT(CLOCK_RATIO_SELECT),
        .SERIAL_MODE(SERIAL_MODE),
        .BCLK_INVERT(BCLK_INVERT),
        .DIGITAL_POWERDOWN(DIGITAL_POWERDOWN),
        .SAMPLE_STROBE(SAMPLE_STROBE),
        .LEFT_LEVEL(LEFT_LEVEL),
        .RIGHT_LEVEL(RIGHT_LEVEL),
        .WORD_SELECT_I(ws_w),
        .WORD_SELECT_O(WORD_SELECT_O),
        .WORD_SELECT_OE_N(WORD_SELECT_OE_N),
        .BIT_CLOCK_I(bc_w),
        .BIT_CLOCK_O(BIT_CLOCK_O),
        .BIT_CLOCK_OE_N(BIT_CLOCK_OE_N),
        .FRAME_ENABLE_I(fe_w),
        .FRAME_ENABLE_O(FRAME_ENABLE_O),
        .FRAME_ENABLE_OE_N(FRAME_ENABLE_OE_N),
        .MODULATOR_CLOCK_OUT(MODULATOR_CLOCK_OUT),
        .SERIAL_OUT(SERIAL_OUT),
        .CAL_ACTIVE(CAL_ACTIVE)
    );

    host_clock_model u_host_clock_model
    (
        .clk(CLK),
        .rstn(RSTN),
        .run(hrun),
        .host_frame(SERIAL_MODE == SER_SLAVE_HOST),
        .ws(h_ws),
        .bclk(h_bc),
        .fe(h_fe)
    );

    // ====================================================================
    // Helpers
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Host framing skips bit clocks before frame enable rises and after
    // it falls, so the expected stream repeats the held bit there.
    function automatic logic [31:0] expw(logic signed [LEVEL_W-1:0] lv,
        logic rt);
        logic [LEVEL_W-1:0] m;
        logic [15:0] s;
        logic [2:0] t;
        logic [23:0] w;
        logic [31:0] o;
        m = lv[LEVEL_W-1] ? -lv : lv;
        s = lv > LEVEL_POS_LIM ? SAMPLE_MAX : lv < LEVEL_NEG_LIM ? SAMPLE_MIN
            : lv[15:0];
        t = m >= LVL_1375 ? TAG_OVR3 : m >= LVL_1250 ? TAG_OVR2
            : m >= LVL_1125 ? TAG_OVR1 : m >= LVL_FS ? TAG_OVR0
            : m >= LVL_M1DB ? TAG_NEAR1 : m >= LVL_M3DB ? TAG_NEAR3
            : m >= LVL_M6DB ? TAG_NEAR6 : TAG_LOW;
        w = {s, t, rt, {4{!rt}}};
        o = {8'h0, w};
        if (SERIAL_MODE == SER_MASTER)
            o = {s[15], s, t, rt, {11{!rt}}};
        if (SERIAL_MODE == SER_SLAVE_HOST)
            for (int j = 0; j < 24; j++)
                o[23-j] = w[23-(j < 5 ? 0 : j < 22 ? j - 4 : 17)];
        return o;
    endfunction

    task automatic check(logic [31:0] seen, logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tmo(int k, int lim);
        if (k >= lim)
        begin
            fail_count++;
            results();
        end
    endtask

    task automatic wait_ws(logic v);
        int k;
        k = 0;
        while (ws_w !== v && k < 2000)
        begin
            @(posedge CLK);
            k++;
        end
        tmo(k, 2000);
    endtask

    task automatic power_up();
        int k;
        int f;
        k = 0;
        DIGITAL_POWERDOWN <= 1'b1;
        repeat (10) @(posedge CLK);
        f = CLOCK_RATIO_SELECT ? 384 : 256;
        check({SERIAL_OUT, FRAME_ENABLE_O, MODULATOR_CLOCK_OUT}, 3'h0);
        DIGITAL_POWERDOWN <= 1'b0;
        while (CAL_ACTIVE !== 1'b1 && k < 20)
        begin
            @(posedge CLK);
            k++;
        end
        k = 0;
        while (CAL_ACTIVE !== 1'b0 && k < 6000)
        begin
            @(posedge CLK);
            k++;
        end
        check(32'(k >= 3 * f && k <= 5 * f), 32'h1);
    endtask

    // Levels are strobed 20 clocks into the right half, so the next left load takes them.
    task automatic frames(int n, logic rnd);
        int k;
        logic signed [LEVEL_W-1:0] l;
        logic signed [LEVEL_W-1:0] r;
        for (int i = 0; i < n; i++)
        begin
            wait_ws(1'b1);
            wait_ws(1'b0);
            repeat (20) @(posedge CLK);
            seed = lfsr(seed);
            l = rnd ? {{3{seed[14]}}, seed[14:0]} : tbl[i % 11];
            r = rnd ? {{3{seed[30]}}, seed[30:16]} : tbl[(i + 1) % 11];
            LEFT_LEVEL <= l;
            RIGHT_LEVEL <= r;
            SAMPLE_STROBE <= 1'b1;
            q.push_back(expw(l, 1'b0));
            q.push_back(expw(r, 1'b1));
            @(posedge CLK);
            SAMPLE_STROBE <= 1'b0;
        end
        k = 0;
        while (q.size() > 0 && k < 3000)
        begin
            @(posedge CLK);
            k++;
        end
        tmo(k, 3000);
    endtask

    // ====================================================================
    // Output monitor
    always @(posedge CLK)
    begin
        if (ws_w !== ws_q)
        begin
            if (armed)
            begin
                check(got, q.pop_front());
                check(mods, 64);
                check({WORD_SELECT_OE_N, BIT_CLOCK_OE_N, FRAME_ENABLE_OE_N},
                    {3{SERIAL_MODE != SER_MASTER}});
                if (per != 8)
                begin
                    check(rises, 32);
                    check(feh, 16 * per);
                    check({bc, FRAME_ENABLE_O}, 2'b10);
                end
            end
            armed = q.size() > 0;
            cnt = 0;
            rises = 0;
            feh = 0;
            mods = 0;
            got = 32'h0;
        end
        else
            cnt++;
        rises += (bc && !bc_q);
        feh += FRAME_ENABLE_O;
        mods += MODULATOR_CLOCK_OUT;
        if (cnt % per == smp)
            got = {got[30:0], SERIAL_OUT};
        ws_q = ws_w;
        bc_q = bc;
    end

    // ====================================================================
    // Main sequence
    initial
    begin
        RSTN = 1'b0;
        CLK_EN = 1'b1;
        CLOCK_RATIO_SELECT = 1'b0;
        BCLK_INVERT = 1'b0;
        DIGITAL_POWERDOWN = 1'b1;
        SAMPLE_STROBE = 1'b0;
        SERIAL_MODE = SER_MASTER;
        LEFT_LEVEL = '0;
        RIGHT_LEVEL = '0;
        hrun = 1'b0;
        armed = 1'b0;
        seed = 32'h28d360ac;
        repeat (16) @(posedge CLK);
        RSTN <= 1'b1;
        power_up();
        frames(11, 1'b0);
        CLOCK_RATIO_SELECT <= 1'b1;
        BCLK_INVERT <= 1'b1;
        power_up();
        frames(4, 1'b1);
        SERIAL_MODE <= SER_SLAVE_FIXED;
        BCLK_INVERT <= 1'b0;
        hrun <= 1'b1;
        power_up();
        frames(4, 1'b1);
        SERIAL_MODE <= SER_SLAVE_HOST;
        power_up();
        frames(11, 1'b0);
        results();
    end
endmodule
